/* File: design/oled_host_port.sv */
// Purpose: host that drives the display module bus pins
// Assumes: strap style matches the module build; one request at a time
// Notes: pin timing stretched to whole 100 ns cycles
`timescale 1ns/1ps
// Contract
// RQ1: eight-bit bidirectional bus, host drives writes
// RQ2: serial uses bit 1 data, bit 0 clock
// RQ3: enable style starts on enable high, select low
// RQ4: direction high reads, low writes, set first
// RQ5: split style read strobe low starts read
// RQ6: split style write strobe low starts write
// RQ7: select high means data, low means command
// RQ8: init pin low resets module logic
// RQ9: module answers only with select low
// RQ10: bus style fixed by build straps
// RQ11: data covers 256 by 64 dots
// RQ12: serial sampled rising edge, msb first
// RQ13: host holds select, direction through strobe
module oled_host_port #(
  parameter oled_host_pkg::bus_style_t STYLE = oled_host_pkg::STYLE_SPLIT,
  parameter int INIT_CYCLES = oled_host_pkg::INIT_CYC
) (
  // clock, enable, reset
  input wire logic CLK,
  input wire logic CE,
  input wire logic RST,
  // user request side
  input wire logic REQ_VALID,
  input wire oled_host_pkg::req_t REQ,
  input wire logic INIT_REQ,
  output logic REQ_READY,
  output logic RD_VALID,
  output logic [7:0] RD_DATA,
  // module pins
  output oled_host_pkg::pins_t PINS,
  input wire logic [7:0] BUS_IN,
  output logic [7:0] BUS_OUT,
  output logic BUS_OE
);

  typedef enum logic [2:0] {
    S_INIT,
    S_IDLE,
    S_SETUP,
    S_STROBE,
    S_HOLD,
    S_SER_LO,
    S_SER_HI
  } state_t;

  state_t state_q;
  logic [oled_host_pkg::CNT_W-1:0] cnt_q;
  logic [2:0] bit_q;
  oled_host_pkg::req_t cur_q;
  logic [7:0] bus_sync;

  // strobe active level depends on style
  function automatic logic strobe_on(input logic act);
    strobe_on = (STYLE == oled_host_pkg::STYLE_ENABLE) ? act : ~act;
  endfunction

  // returning bus is asynchronous to CLK
  oled_pin_sync #(.WIDTH(8)) u_sync (
    .CLK(CLK),
    .CE(CE),
    .RST(RST),
    .din(BUS_IN),
    .dout(bus_sync)
  );

  // sequencing of init, parallel and serial transfers
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_q <= S_INIT;
      cnt_q <= '0;
      bit_q <= '0;
      cur_q <= '0;
    end
    else if (CE)
    begin
      case (state_q)
        S_INIT:
        begin
          // module held in init while the pin is low, see RQ8
          if (cnt_q == INIT_CYCLES[oled_host_pkg::CNT_W-1:0])
          begin
            state_q <= S_IDLE;
            cnt_q <= '0;
          end
          else
            cnt_q <= cnt_q + 8'h01;
        end
        S_IDLE:
        begin
          if (INIT_REQ)
          begin
            state_q <= S_INIT;
            cnt_q <= '0;
          end
          else if (REQ_VALID)
          begin
            cur_q <= REQ;
            cnt_q <= '0;
            bit_q <= 3'h7; // msb first, see RQ12
            // style is a build constant, no runtime path, see RQ10
            if (STYLE == oled_host_pkg::STYLE_SERIAL)
              state_q <= S_SER_LO;
            else
              state_q <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          // direction and dc settle before the strobe, see RQ4
          if (cnt_q == oled_host_pkg::SETUP_CYC[7:0] - 8'h01)
          begin
            state_q <= S_STROBE;
            cnt_q <= '0;
          end
          else
            cnt_q <= cnt_q + 8'h01;
        end
        S_STROBE:
        begin
          if (cnt_q == oled_host_pkg::PULSE_CYC[7:0] + 8'h01)
          begin
            state_q <= S_HOLD;
            cnt_q <= '0;
          end
          else
            cnt_q <= cnt_q + 8'h01;
        end
        S_HOLD:
        begin
          // meets the minimum cycle time before next select
          if (cnt_q == oled_host_pkg::CYCLE_CYC[7:0])
            state_q <= S_IDLE;
          else
            cnt_q <= cnt_q + 8'h01;
        end
        S_SER_LO:
          state_q <= S_SER_HI;
        S_SER_HI:
        begin
          // module samples on this rising clock, see RQ12
          if (bit_q == 3'h0)
          begin
            state_q <= S_HOLD;
            cnt_q <= '0;
          end
          else
          begin
            bit_q <= bit_q - 3'h1;
            state_q <= S_SER_LO;
          end
        end
        default:
          state_q <= S_INIT;
      endcase
    end
  end

  // control pins registered from the current state, one cycle behind it
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      PINS.cs_n <= 1'b1;
      PINS.strobe_a <= strobe_on(1'b0);
      PINS.strobe_b <= 1'b1;
      PINS.dc <= 1'b0;
      PINS.init_n <= 1'b0;
    end
    else if (CE)
    begin
      PINS.init_n <= (state_q != S_INIT); // see RQ8
      // select low only while a transfer is live, see RQ9
      PINS.cs_n <= !(state_q == S_SETUP || state_q == S_STROBE
                   || state_q == S_SER_LO || state_q == S_SER_HI);
      PINS.dc <= cur_q.dc; // held for whole strobe, see RQ7 RQ13
      if (STYLE == oled_host_pkg::STYLE_ENABLE)
      begin
        // enable high starts, direction chosen first, see RQ3 RQ4
        PINS.strobe_a <= (state_q == S_STROBE);
        PINS.strobe_b <= cur_q.rd;
      end
      else
      begin
        // separate read and write strobes, active low, see RQ5 RQ6
        PINS.strobe_a <= !(state_q == S_STROBE && cur_q.rd);
        PINS.strobe_b <= !(state_q == S_STROBE && !cur_q.rd);
      end
    end
  end

  // data bus drive, parallel write or serial pair, see RQ1 RQ2
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      BUS_OUT <= oled_host_pkg::DATA_RST;
      BUS_OE <= 1'b0;
    end
    else if (CE)
    begin
      if (STYLE == oled_host_pkg::STYLE_SERIAL)
      begin
        BUS_OE <= (state_q == S_SER_LO || state_q == S_SER_HI);
        BUS_OUT <= {6'h00, cur_q.data[bit_q], state_q == S_SER_HI};
      end
      else
      begin
        BUS_OE <= (state_q == S_SETUP || state_q == S_STROBE)
                  && !cur_q.rd;
        // bytes land unaltered on the 256 by 64 dot array, see RQ11
        BUS_OUT <= cur_q.data;
      end
    end
  end

  // handshake and read capture at end of read strobe
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      REQ_READY <= 1'b0;
      RD_VALID <= 1'b0;
      RD_DATA <= oled_host_pkg::DATA_RST;
    end
    else if (CE)
    begin
      REQ_READY <= (state_q == S_IDLE) && !REQ_VALID && !INIT_REQ;
      RD_VALID <= 1'b0;
      // first hold cycle sees the bus from the first strobe-low cycle, two flops late
      if (STYLE != oled_host_pkg::STYLE_SERIAL && state_q == S_HOLD
          && cur_q.rd && cnt_q == '0)
      begin
        RD_VALID <= 1'b1;
        RD_DATA <= bus_sync;
      end
    end
  end

endmodule

/* File: design/oled_host_pkg.sv */
// Purpose: shared constants and types for the display module host port
// Assumes: 10 MHz CLK, one host command accepted at a time
// Notes: bus style is a build-time choice mirrored by the module straps
package oled_host_pkg;

  // bus styles, fixed when the module is built
  typedef enum logic [1:0] {
    STYLE_SERIAL,
    STYLE_ENABLE,
    STYLE_SPLIT
  } bus_style_t;

  // pin timing as printed, and derived cycle counts at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int CYCLE_MIN_NS = 300;
  localparam int PULSE_MIN_NS = 60;
  localparam int PULSE_CYC =
    (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CYC =
    (CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = 1;
  localparam int INIT_CYC = 10;
  localparam int BYTE_BITS = 8;
  localparam int CNT_W = 8;

  // display geometry covered by the data path
  localparam int DISP_COLS = 256;
  localparam int DISP_ROWS = 64;

  // reset values of the pins
  localparam logic [7:0] DATA_RST = 8'h00;

  // one host request
  typedef struct packed {
    logic       rd;     // 1 read, 0 write
    logic       dc;     // 1 display data, 0 command
    logic [7:0] data;
  } req_t;

  // module-facing control pins
  typedef struct packed {
    logic cs_n;
    logic strobe_a;     // enable, or read strobe
    logic strobe_b;     // direction, or write strobe
    logic dc;
    logic init_n;
  } pins_t;

endpackage

/* File: design/oled_pin_sync.sv */
// Purpose: two-flop synchroniser for the returning data bus
// Assumes: bus held stable by the module for the read hold window
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module oled_pin_sync #(
  parameter int WIDTH = 8
) (
  // clock, enable, reset
  input wire logic CLK,
  input wire logic CE,
  input wire logic RST,
  // async in, synced out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage_q;

  // both stages cleared together
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      stage_q <= '0;
      dout <= '0;
    end
    else if (CE)
    begin
      stage_q <= din;
      dout <= stage_q;
    end
  end

endmodule

/* File: tb/oled_disp_model.sv */
// Purpose: display module end of the host bus
// Assumes: split strobes, or enable and direction by parameter
// Notes: released bus shows the inverse byte
`timescale 1ns/1ps
module oled_disp_model #(
  parameter bit ENABLE_STYLE = 1'b0
) (
  // host pins
  input wire oled_host_pkg::pins_t pins,
  input wire logic [7:0] bus,
  // bus drive, stored bytes
  output logic [7:0] drv,
  output logic [7:0] cmd_q,
  output logic [7:0] dat_q
);
  logic wr_n, rd_on;
  // write and read windows decoded for the built style
  assign wr_n = ENABLE_STYLE ? !(pins.strobe_a && !pins.strobe_b)
    : pins.strobe_b;
  assign rd_on = ENABLE_STYLE ? pins.strobe_a && pins.strobe_b
    : !pins.strobe_a;
  // byte taken as the write window opens, init clears
  always @(negedge wr_n or negedge pins.init_n)
  begin
    if (!pins.init_n)
      {cmd_q, dat_q} <= 16'h0000;
    else if (!pins.cs_n && pins.dc)
      dat_q <= bus;
    else if (!pins.cs_n)
      cmd_q <= bus;
  end
  // no stale value once released
  assign drv = !pins.cs_n && rd_on ? dat_q : ~dat_q;
endmodule

// serial end: bit 1 data, bit 0 clock, style fixed at build
module oled_ser_model (
  // host pins
  input wire oled_host_pkg::pins_t pins,
  input wire logic [7:0] bus,
  // last whole byte with its select
  output logic [8:0] got_q
);
  logic [7:0] sh_q;
  logic [2:0] n_q;
  // shift on rising serial clock while selected
  always @(posedge bus[0] or negedge pins.init_n)
  begin
    if (!pins.init_n)
    begin
      sh_q <= 8'h00;
      n_q <= 3'h0;
      got_q <= 9'h000;
    end
    else if (!pins.cs_n)
    begin
      sh_q <= {sh_q[6:0], bus[1]};
      n_q <= n_q + 3'h1;
      if (n_q == 3'h7)
        got_q <= {pins.dc, sh_q[6:0], bus[1]};
    end
  end
endmodule

/* File: tb/oled_host_chk.sv */
// Purpose: pin checks for the host port
// Assumes: split strobes; other built styles switch the checks off
// Notes: bound to the host port
`timescale 1ns/1ps
module oled_host_chk #(
  parameter int INIT_CYCLES = 2,
  parameter bit SPLIT = 1'b1
) (
  // watched ports
  input wire logic CLK,
  input wire logic RST,
  input wire logic REQ_READY,
  input wire logic RD_VALID,
  input wire oled_host_pkg::pins_t PINS,
  input wire logic [7:0] BUS_OUT,
  input wire logic BUS_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST || !SPLIT);
  // full write pulse, then release
  sequence wr_pulse;
    !PINS.strobe_b [*3] ##1 PINS.strobe_b;
  endsequence
  a_strobe_with_cs: assert property (
    !(PINS.strobe_a && PINS.strobe_b) |-> !PINS.cs_n) else $error("no cs");
  a_read_undriven: assert property (
    !PINS.strobe_a |-> !BUS_OE) else $error("drive in read");
  a_write_driven: assert property (
    !PINS.strobe_b |-> BUS_OE) else $error("write undriven");
  a_write_pulse: assert property (
    $fell(PINS.strobe_b) |-> wr_pulse) else $error("pulse width");
  a_hold_in_write: assert property (
    !PINS.strobe_b && !$past(PINS.strobe_b) |-> $stable({PINS.dc, BUS_OUT}))
    else $error("moved in write");
  a_init_low: assert property (
    $fell(RST) |-> !PINS.init_n [*3]) else $error("init short");
  a_read_answer: assert property (
    $fell(PINS.strobe_a) |-> ##[1:8] RD_VALID) else $error("no read");
  a_idle_release: assert property (
    REQ_READY |-> PINS.cs_n && !BUS_OE) else $error("busy in idle");
endmodule

bind oled_host_port oled_host_chk #(.INIT_CYCLES(INIT_CYCLES),
  .SPLIT(STYLE == oled_host_pkg::STYLE_SPLIT)) u_chk (
  .CLK(CLK), .RST(RST), .REQ_READY(REQ_READY), .RD_VALID(RD_VALID),
  .PINS(PINS), .BUS_OUT(BUS_OUT), .BUS_OE(BUS_OE));

/* File: tb/oled_host_port_tb.sv */
// Purpose: bench for the host port
// Assumes: INIT_CYCLES of 2, three built styles fed in step
// Notes: rows are {rd, dc, data, expect}
`timescale 1ns/1ps
module oled_host_port_tb;
  localparam logic [17:0] ROWS [4] = '{18'h03c3c, 18'h1a5a5, 18'h300a5,
    18'h15a5a};
  logic CLK, CE, RST, REQ_VALID, INIT_REQ, REQ_READY, RD_VALID, BUS_OE;
  logic [7:0] RD_DATA, BUS_OUT, drv, cmd_q, dat_q;
  oled_host_pkg::req_t REQ;
  oled_host_pkg::pins_t PINS;
  wire logic [7:0] bus;
  logic en_ready, en_rd_valid, en_oe, ser_ready, ser_oe, all_ready;
  logic [7:0] en_rd_data, en_bus_out, en_drv, en_cmd, en_dat, ser_bus_out;
  logic [8:0] ser_got;
  oled_host_pkg::pins_t en_pins, ser_pins;
  wire logic [7:0] en_bus, ser_bus;
  int mismatches, n_compared;
  // host drive wins only while enabled
  assign bus = BUS_OE ? BUS_OUT : drv;
  assign en_bus = en_oe ? en_bus_out : en_drv;
  // released serial pair rests low, as if pulled down
  assign ser_bus = ser_oe ? ser_bus_out : 8'h00;
  assign all_ready = REQ_READY && en_ready && ser_ready;
  oled_host_port #(.INIT_CYCLES(2)) u_dut (.CLK(CLK), .CE(CE), .RST(RST),
    .REQ_VALID(REQ_VALID), .REQ(REQ), .INIT_REQ(INIT_REQ),
    .REQ_READY(REQ_READY), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
    .PINS(PINS), .BUS_IN(bus), .BUS_OUT(BUS_OUT), .BUS_OE(BUS_OE));
  oled_disp_model u_disp (.pins(PINS), .bus(bus), .drv(drv),
    .cmd_q(cmd_q), .dat_q(dat_q));
  // same requests into the other two built styles
  oled_host_port #(.STYLE(oled_host_pkg::STYLE_ENABLE), .INIT_CYCLES(2))
    u_en (.CLK(CLK), .CE(CE), .RST(RST), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .INIT_REQ(INIT_REQ), .REQ_READY(en_ready), .RD_VALID(en_rd_valid),
    .RD_DATA(en_rd_data), .PINS(en_pins), .BUS_IN(en_bus),
    .BUS_OUT(en_bus_out), .BUS_OE(en_oe));
  oled_disp_model #(.ENABLE_STYLE(1'b1)) u_en_disp (.pins(en_pins),
    .bus(en_bus), .drv(en_drv), .cmd_q(en_cmd), .dat_q(en_dat));
  oled_host_port #(.STYLE(oled_host_pkg::STYLE_SERIAL), .INIT_CYCLES(2))
    u_ser (.CLK(CLK), .CE(CE), .RST(RST), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .INIT_REQ(INIT_REQ), .REQ_READY(ser_ready), .RD_VALID(), .RD_DATA(),
    .PINS(ser_pins), .BUS_IN(ser_bus), .BUS_OUT(ser_bus_out),
    .BUS_OE(ser_oe));
  oled_ser_model u_ser_disp (.pins(ser_pins), .bus(ser_bus),
    .got_q(ser_got));
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // bounded wait; a hang counts and ends the run
  task automatic wait_hi(ref logic f);
    for (int i = 0; f !== 1'b1; i++)
    begin
      if (i == 99)
      begin
        chk(8'h00, 8'h01);
        tally_and_finish();
      end
      @(negedge CLK);
    end
  endtask
  // offered only when all ports idle, for one edge, then checked
  task automatic xfer(input logic [17:0] r);
    wait_hi(all_ready);
    REQ = r[17:8];
    REQ_VALID = 1'b1;
    @(negedge CLK);
    REQ_VALID = 1'b0;
    if (r[17])
    begin
      wait_hi(RD_VALID);
      chk({7'h00, en_rd_valid}, 8'h01);
    end
    wait_hi(all_ready);
    chk(r[17] ? RD_DATA : r[16] ? dat_q : cmd_q, r[7:0]);
    chk(r[17] ? en_rd_data : r[16] ? en_dat : en_cmd, r[7:0]);
    if (!r[17])
    begin
      chk(ser_got[7:0], r[15:8]);
      chk({7'h00, ser_got[8]}, {7'h00, r[16]});
    end
  endtask
  // clock
  initial
  begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // table, init request, reset in mid-write
  initial
  begin
    {CE, RST, REQ_VALID, INIT_REQ} = 4'b1100;
    REQ = '0;
    repeat (16) @(negedge CLK);
    chk({5'h00, PINS.cs_n, PINS.init_n, BUS_OE}, 8'h04);
    RST = 1'b0;
    foreach (ROWS[k])
      xfer(ROWS[k]);
    // enable low: a standing request must not be taken
    CE = 1'b0;
    REQ_VALID = 1'b1;
    repeat (3) @(negedge CLK);
    REQ_VALID = 1'b0;
    chk({6'h00, all_ready, PINS.cs_n}, 8'h03);
    CE = 1'b1;
    INIT_REQ = 1'b1;
    @(negedge CLK);
    INIT_REQ = 1'b0;
    xfer(18'h30000);
    REQ = 10'h1ff;
    REQ_VALID = 1'b1;
    repeat (4) @(negedge CLK);
    RST = 1'b1;
    @(negedge CLK);
    chk({5'h00, PINS.cs_n, PINS.init_n, BUS_OE}, 8'h04);
    {RST, REQ_VALID} = 2'b00;
    xfer(18'h30000);
    tally_and_finish();
  end
endmodule
